// ---- core/fpe_divider.sv ----
// Sequential restoring divider, one quotient bit per clock.
// Assumes i_start is only pulsed while o_busy is low.
`timescale 1ns/1ps
`include "fpe_map.svh"

module fpe_divider
	import fpe_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic [39:0] i_num,
	input wire logic [23:0] i_den,
	output logic o_busy,
	output logic o_done,
	output logic [39:0] o_quot
);

	logic [24:0] rem;
	logic [5:0] steps;
	logic [25:0] trial;
	logic [24:0] shifted;

	// Trial subtraction for the next quotient bit
	assign shifted = {rem[23:0], o_quot[39]};
	assign trial = {1'b0, shifted} - {2'b00, i_den};

	// Shift and subtract loop
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rem <= 25'h000_0000;
			steps <= 6'h00;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_quot <= 40'h00_0000_0000;
		end
		else if (i_start)
		begin
			rem <= 25'h000_0000;
			steps <= `FPE_DIV_STEPS;
			o_busy <= 1'b1;
			o_done <= 1'b0;
			o_quot <= i_num;
		end
		else if (o_busy)
		begin
			rem <= trial[25] ? shifted : trial[24:0];
			o_quot <= {o_quot[38:0], ~trial[25]};
			steps <= steps - 6'h01;
			o_busy <= (steps != 6'h01);
			o_done <= (steps == 6'h01);
		end
		else
			o_done <= 1'b0;
	end

endmodule

// ---- core/fpe_element.sv ----
// One frequency protection element: pickup, delay timer, alarm, trip.
// Assumes measured values arrive with a one-cycle update strobe.
`timescale 1ns/1ps

module fpe_element
	import fpe_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire fpe_cfg_t i_cfg,
	input wire fpe_meas_t i_meas,
	input wire logic i_block,
	output logic o_alarm,
	output logic o_trip
);

	logic [31:0] timer;
	logic signed [24:0] grad_x;
	logic signed [24:0] thr_x;
	logic rate_hit;
	logic pickup;
	logic timer_done;

	// Gradient compare by direction; sign kept so falls read negative
	assign grad_x = {i_meas.grad[23], i_meas.grad};
	assign thr_x = {1'b0, i_cfg.thresh};
	assign rate_hit = (i_cfg.dir == FPE_DIR_POS) ? (grad_x > thr_x) :
		(i_cfg.dir == FPE_DIR_NEG) ? (grad_x < -thr_x) :
		(grad_x > thr_x) || (grad_x < -thr_x);

	// Only the plain modes pick up; combined modes stay quiet
	assign pickup = (i_cfg.mode == FPE_MODE_UNDER) ?
		(i_meas.freq < i_cfg.thresh) :
		(i_cfg.mode == FPE_MODE_OVER) ?
		(i_meas.freq > i_cfg.thresh) :
		(i_cfg.mode == FPE_MODE_RATE) && rate_hit;
	assign timer_done = (timer >= i_cfg.delay);

	// Delay timer runs in clocks while the alarm stands
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			timer <= 32'h0000_0000;
		else if (!o_alarm || i_block)
			timer <= 32'h0000_0000;
		else if (!timer_done)
			timer <= timer + 32'h0000_0001;
	end

	// Alarm and trip refresh with each new value; block acts at once
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_alarm <= 1'b0;
			o_trip <= 1'b0;
		end
		else if (i_block)
		begin
			o_alarm <= 1'b0;
			o_trip <= 1'b0;
		end
		else if (i_meas.update)
		begin
			o_alarm <= pickup;
			o_trip <= pickup && o_alarm && timer_done;
		end
	end

endmodule

// ---- core/fpe_map.svh ----
// Register offsets, field positions, reset values and timing counts
// of the frequency protection element; included by the design files.
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH

// ****************************************************************
// Register map (byte addresses, one 32-bit word each)
// ****************************************************************
`define FPE_VBLOCK_OFF 12'h000
`define FPE_WINDOW_OFF 12'h004
`define FPE_FREQ_OFF 12'h008
`define FPE_GRAD_OFF 12'h00C
`define FPE_FLAGS_OFF 12'h010
`define FPE_ELEM_BASE 12'h040
`define FPE_ELEM_END 12'h0A0
`define FPE_EL_MODE 2'h0
`define FPE_EL_THRESH 2'h1
`define FPE_EL_DELAY 2'h2

// ****************************************************************
// Window register fields and reset values
// ****************************************************************
`define FPE_AVG_LSB 0
`define FPE_MEAS_LSB 8
`define FPE_SRC_LSB 16
`define FPE_GSM_LSB 24
`define FPE_WINDOW_RST 32'h0203_0200
`define FPE_VBLOCK_RST 16'h0000
`define FPE_MEAS_MIN 4'h2
`define FPE_MEAS_MAX 4'hA
`define FPE_WIN_MIN 4'h1
`define FPE_WIN_MAX 4'hA

// ****************************************************************
// Timing
// ****************************************************************
`define FPE_CLK_KHZ 100000
`define FPE_BLOCK_HOLD_MS 500
`define FPE_FZERO_MS 300
`define FPE_GZERO_MS 1000
`define FPE_FREEZE_PERIODS 4'h2
`define FPE_FREQ_NUM 40'h17_4876_E800
`define FPE_NOMINAL_HZ 36'h0_0000_0032
`define FPE_DIV_STEPS 6'h28

`endif

// ---- core/fpe_pkg.sv ----
// Types shared by the frequency protection element design files.
// Assumes the register map header is included where offsets are used.
package fpe_pkg;

	// Element operating modes
	typedef enum logic [2:0] {
		FPE_MODE_UNDER = 3'b000,
		FPE_MODE_OVER = 3'b001,
		FPE_MODE_RATE = 3'b010,
		FPE_MODE_UNDER_RATE = 3'b011,
		FPE_MODE_OVER_RATE = 3'b100,
		FPE_MODE_UNDER_IVD = 3'b101,
		FPE_MODE_OVER_IVD = 3'b110,
		FPE_MODE_SURGE = 3'b111
	} fpe_mode_t;

	// Gradient direction
	typedef enum logic [1:0] {
		FPE_DIR_POS = 2'b00,
		FPE_DIR_NEG = 2'b01,
		FPE_DIR_ABS = 2'b10
	} fpe_dir_t;

	// Per-element settings
	typedef struct packed {
		fpe_mode_t mode;
		fpe_dir_t dir;
		logic [23:0] thresh;
		logic [31:0] delay;
	} fpe_cfg_t;

	// Measured values handed to the elements
	typedef struct packed {
		logic [23:0] freq;
		logic signed [23:0] grad;
		logic update;
	} fpe_meas_t;

endpackage

// ---- core/fpe_top.sv ----
// Frequency measurement and six protection elements behind an APB slave.
// Assumes one zero-crossing pulse per phase per cycle, synchronous inputs.
//
// Function
// - System frequency is the mean of valid phase frequencies only.
// - Frequency comes from full cycle times, refreshed at each crossing.
// - Low voltage blocks frequency measurement and dependent protection.
// - After recovery: block 0.5 s, frequency zero 0.3 s, gradient zero 1 s.
// - Frequency is smoothed over a settable averaging window.
// - Phase jump or surge freezes frequency two periods, zeroes gradient; only i_phase_jump triggers it, there is no surge input.
// - Six identical elements, each set to one of eight modes.
// - Underfrequency: alarm at once, trip after full delay below threshold.
// - Overfrequency: alarm at once, trip after full delay above threshold.
// - Pickup without block raises alarm and starts the delay timer.
// - Gradient is computed once per period, at the crossing of the first valid phase.
// - Gradient window is settable from 2 to 10 nominal periods.
// - Gradient uses raw frequency, before averaging and freezing.
// - A separate settable smoothing window filters gradient values.
// - Gradient is signed: positive rising, negative falling.
// - Gradient direction: positive, negative or absolute.
// - Gradient mode: alarm at once, trip if it persists through delay.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fpe_map.svh"

module fpe_top
	import fpe_pkg::*;
#(
	parameter int unsigned BLOCK_HOLD_CYC = `FPE_BLOCK_HOLD_MS * `FPE_CLK_KHZ,
	parameter int unsigned FZERO_CYC = `FPE_FZERO_MS * `FPE_CLK_KHZ,
	parameter int unsigned GZERO_CYC = `FPE_GZERO_MS * `FPE_CLK_KHZ
)
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [2:0] i_zero_cross,
	input wire logic [2:0] i_phase_ok,
	input wire logic [15:0] i_volt_mag,
	input wire logic i_phase_jump,
	input wire logic [5:0] i_block,
	output logic [5:0] o_alarm,
	output logic [5:0] o_trip
);

	// ************************************************************
	// Shared arithmetic
	// ************************************************************
	// Reciprocal in Q16 avoids a divider for every window mean
	function automatic logic [16:0] recip(input logic [3:0] n);
		unique case (n)
			4'h0: recip = 17'h0_0000;
			4'h1: recip = 17'h1_0000;
			4'h2: recip = 17'h0_8000;
			4'h3: recip = 17'h0_5556;
			4'h4: recip = 17'h0_4000;
			4'h5: recip = 17'h0_3333;
			4'h6: recip = 17'h0_2AAB;
			4'h7: recip = 17'h0_2492;
			4'h8: recip = 17'h0_2000;
			4'h9: recip = 17'h0_1C72;
			4'hA: recip = 17'h0_199A;
			4'hB: recip = 17'h0_1746;
			4'hC: recip = 17'h0_1555;
			4'hD: recip = 17'h0_13B1;
			4'hE: recip = 17'h0_1249;
			4'hF: recip = 17'h0_1111;
		endcase
	endfunction

	// Mean of the newest n history entries
	function automatic logic signed [31:0] win_mean(
		input logic signed [31:0] h [16], input logic [3:0] n);
		logic signed [35:0] sum;
		logic signed [53:0] prod;
		sum = 36'sh0_0000_0000;
		prod = 54'sh0;
		for (int i = 0; i < 16; i++)
			if (i < int'(n))
				sum = sum + 36'(h[i]);
		prod = 54'(sum) * 54'($signed({1'b0, recip(n)}));
		win_mean = prod[47:16];
	endfunction

	// Keeps a window setting inside its legal range
	function automatic logic [3:0] clamp(input logic [3:0] v,
		input logic [3:0] lo, input logic [3:0] hi);
		clamp = (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction

	// ************************************************************
	// APB register file
	// ************************************************************
	logic [15:0] vblock;
	logic [31:0] window;
	fpe_cfg_t cfg [6];
	logic [23:0] f_sys;
	logic signed [23:0] g_sys;
	logic blocked, fzero, gzero, frozen;
	logic [11:0] el_off;
	logic [2:0] el_idx;
	logic [1:0] el_fld;
	logic el_hit, hit, wr_acc;
	logic [31:0] el_word, rd_word;

	assign el_off = i_paddr - `FPE_ELEM_BASE;
	assign el_idx = el_off[6:4];
	assign el_fld = el_off[3:2];
	assign el_hit = (i_paddr >= `FPE_ELEM_BASE) &&
		(i_paddr < `FPE_ELEM_END) && (el_fld != 2'h3);
	assign hit = (i_paddr[1:0] == 2'h0) && (el_hit ||
		(i_paddr <= `FPE_FLAGS_OFF));
	assign wr_acc = i_psel && i_penable && o_pready && i_pwrite && hit;
	assign el_word = (el_fld == `FPE_EL_MODE) ?
		{26'h000_0000, cfg[el_idx].dir, 1'b0, cfg[el_idx].mode} :
		(el_fld == `FPE_EL_THRESH) ? {8'h00, cfg[el_idx].thresh} :
		cfg[el_idx].delay;
	assign rd_word = el_hit ? el_word :
		(i_paddr == `FPE_VBLOCK_OFF) ? {16'h0000, vblock} :
		(i_paddr == `FPE_WINDOW_OFF) ? window :
		(i_paddr == `FPE_FREQ_OFF) ? {8'h00, f_sys} :
		(i_paddr == `FPE_GRAD_OFF) ? 32'(g_sys) :
		{12'h000, frozen, gzero, fzero, blocked,
		2'h0, o_trip, 2'h0, o_alarm};

	// Zero-wait slave: answer registered in the setup cycle
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end
		else
		begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !hit;
			o_prdata <= (i_psel && !i_penable && hit && !i_pwrite) ?
				rd_word : 32'h0000_0000;
		end
	end

	// Writable settings; status words ignore writes
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			vblock <= `FPE_VBLOCK_RST;
			window <= `FPE_WINDOW_RST;
			for (int e = 0; e < 6; e++)
				cfg[e] <= '0;
		end
		else if (wr_acc && el_hit)
		begin
			if (el_fld == `FPE_EL_MODE)
			begin
				cfg[el_idx].mode <= fpe_mode_t'(i_pwdata[2:0]);
				cfg[el_idx].dir <= fpe_dir_t'(i_pwdata[5:4]);
			end
			else if (el_fld == `FPE_EL_THRESH)
				cfg[el_idx].thresh <= i_pwdata[23:0];
			else
				cfg[el_idx].delay <= i_pwdata;
		end
		else if (wr_acc && i_paddr == `FPE_VBLOCK_OFF)
			vblock <= i_pwdata[15:0];
		else if (wr_acc && i_paddr == `FPE_WINDOW_OFF)
			window <= i_pwdata;
	end

	// ************************************************************
	// Period measurement and per-phase frequency
	// ************************************************************
	logic [23:0] cnt [3];
	logic [23:0] per [3];
	logic [23:0] phf [3];
	logic [2:0] seen, pend, fval;
	logic [1:0] cur;
	logic [1:0] sel;
	logic dv_start, dv_busy, dv_done;
	logic [39:0] dv_quot;

	assign sel = pend[0] ? 2'd0 : pend[1] ? 2'd1 : 2'd2;
	assign dv_start = !dv_busy && !dv_done && (pend != 3'b000);

	// One shared divider turns each period into a frequency in mHz
	// Divisor follows the phase under way, not the next one queued
	fpe_divider u_div (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_start(dv_start),
		.i_num(`FPE_FREQ_NUM),
		.i_den(per[cur]),
		.o_busy(dv_busy),
		.o_done(dv_done),
		.o_quot(dv_quot)
	);

	// Cycle timing per phase; a new crossing wins over pending clear
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int p = 0; p < 3; p++)
			begin
				cnt[p] <= 24'h00_0000;
				per[p] <= 24'h00_0001;
				phf[p] <= 24'h00_0000;
			end
			seen <= 3'b000;
			pend <= 3'b000;
			fval <= 3'b000;
			cur <= 2'd0;
		end
		else
		begin
			if (dv_start)
			begin
				pend[sel] <= 1'b0;
				cur <= sel;
			end
			if (dv_done)
			begin
				phf[cur] <= (dv_quot[39:24] != 16'h0000) ?
					24'hFF_FFFF : dv_quot[23:0];
				fval[cur] <= 1'b1;
			end
			for (int p = 0; p < 3; p++)
			begin
				if (!i_phase_ok[p])
				begin
					seen[p] <= 1'b0;
					fval[p] <= 1'b0;
					cnt[p] <= 24'h00_0000;
				end
				else if (i_zero_cross[p])
				begin
					cnt[p] <= 24'h00_0000;
					seen[p] <= 1'b1;
					if (seen[p] && cnt[p] != 24'hFF_FFFF)
					begin
						per[p] <= cnt[p] + 24'h00_0001;
						pend[p] <= 1'b1;
					end
				end
				else if (cnt[p] != 24'hFF_FFFF)
					cnt[p] <= cnt[p] + 24'h00_0001;
			end
		end
	end

	// ************************************************************
	// Mean, undervoltage blocking and stabilising
	// ************************************************************
	logic [1:0] nval;
	logic [25:0] fsum;
	logic [50:0] fprod;
	logic [23:0] f_raw;
	logic [1:0] first_ok;
	logic uv;
	logic [31:0] blk_cnt, fz_cnt, gz_cnt;
	logic [3:0] frz_cnt;
	logic [4:0] gjz_cnt;
	logic [3:0] s_stb, t_stb;
	logic [3:0] w_meas, w_src, w_gsm, w_avg;
	logic signed [31:0] fb [16];
	logic signed [31:0] hf [16];
	logic signed [31:0] hs [16];
	logic signed [31:0] hg [16];
	logic signed [31:0] f_avg, src_now, g_avg;
	logic signed [63:0] g_inst;

	// Average over the valid phases only
	assign nval = 2'(fval[0]) + 2'(fval[1]) + 2'(fval[2]);
	assign fsum = (fval[0] ? 26'(phf[0]) : 26'h000_0000) +
		(fval[1] ? 26'(phf[1]) : 26'h000_0000) +
		(fval[2] ? 26'(phf[2]) : 26'h000_0000);
	// A 24-bit reciprocal keeps the three-phase mean within a few mHz
	assign fprod = 51'(fsum) * ((nval == 2'd3) ? 51'h55_5556 :
		(nval == 2'd2) ? 51'h80_0000 : 51'h100_0000);
	assign f_raw = fprod[47:24];
	assign first_ok = fval[0] ? 2'd0 : fval[1] ? 2'd1 : 2'd2;
	assign uv = (i_volt_mag < vblock);
	assign blocked = uv || (blk_cnt != 32'h0000_0000);
	assign fzero = uv || (fz_cnt != 32'h0000_0000);
	assign gzero = uv || (gz_cnt != 32'h0000_0000);
	assign frozen = (frz_cnt != 4'h0);
	assign w_meas = clamp(window[`FPE_MEAS_LSB+:4],
		`FPE_MEAS_MIN, `FPE_MEAS_MAX);
	assign w_src = clamp(window[`FPE_SRC_LSB+:4],
		`FPE_WIN_MIN, `FPE_WIN_MAX);
	assign w_gsm = clamp(window[`FPE_GSM_LSB+:4],
		`FPE_WIN_MIN, `FPE_WIN_MAX);
	assign w_avg = 4'h1 << window[`FPE_AVG_LSB+:2];
	assign f_avg = win_mean(fb, w_avg);
	assign src_now = win_mean(hf, w_src);
	assign g_inst = 64'(hs[0] - hs[w_meas]) *
		64'(`FPE_NOMINAL_HZ) * 64'(recip(w_meas));
	assign g_avg = win_mean(hg, w_gsm);

	// Recovery hold timers restart while the voltage stays low
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			blk_cnt <= 32'h0000_0000;
			fz_cnt <= 32'h0000_0000;
			gz_cnt <= 32'h0000_0000;
		end
		else if (uv)
		begin
			blk_cnt <= BLOCK_HOLD_CYC;
			fz_cnt <= FZERO_CYC;
			gz_cnt <= GZERO_CYC;
		end
		else
		begin
			blk_cnt <= blocked ? blk_cnt - 32'h0000_0001 : blk_cnt;
			fz_cnt <= fzero ? fz_cnt - 32'h0000_0001 : fz_cnt;
			gz_cnt <= gzero ? gz_cnt - 32'h0000_0001 : gz_cnt;
		end
	end

	// Sample pipeline: stage 0 new mean, 1 smooth, 2 gradient, 3 publish
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s_stb <= 4'h0;
			t_stb <= 4'h0;
			frz_cnt <= 4'h0;
			gjz_cnt <= 5'h00;
			f_sys <= 24'h00_0000;
			g_sys <= 24'sh00_0000;
			for (int i = 0; i < 16; i++)
			begin
				fb[i] <= 32'sh0000_0000;
				hf[i] <= 32'sh0000_0000;
				hs[i] <= 32'sh0000_0000;
				hg[i] <= 32'sh0000_0000;
			end
		end
		else
		begin
			s_stb <= {s_stb[2:0], dv_done};
			t_stb <= {t_stb[2:0], dv_done && (cur == first_ok)};
			// Jump reload wins over the per-period count-down
			if (i_phase_jump)
			begin
				frz_cnt <= `FPE_FREEZE_PERIODS + 4'h1;
				gjz_cnt <= 5'(w_meas) + 5'(w_gsm);
			end
			else if (t_stb[0])
			begin
				frz_cnt <= frozen ? frz_cnt - 4'h1 : frz_cnt;
				gjz_cnt <= (gjz_cnt != 5'h00) ? gjz_cnt - 5'h01 : gjz_cnt;
			end
			if (s_stb[0])
				fb <= {32'(f_raw), fb[0:14]};
			if (t_stb[0])
				hf <= {32'(f_raw), hf[0:14]};
			if (t_stb[1])
				hs <= {src_now, hs[0:14]};
			if (t_stb[2])
				hg <= {g_inst[47:16], hg[0:14]};
			// Zeroed during recovery; frequency held, gradient zeroed while a jump settles
			if (fzero || nval == 2'd0)
				f_sys <= 24'h00_0000;
			else if (s_stb[1] && !frozen)
				f_sys <= f_avg[23:0];
			if (gzero || gjz_cnt != 5'h00)
				g_sys <= 24'sh00_0000;
			else if (t_stb[3])
				g_sys <= g_avg[23:0];
		end
	end

	// ************************************************************
	// Protection elements
	// ************************************************************
	fpe_meas_t meas;
	logic [5:0] el_alarm, el_trip;

	assign meas = '{freq: f_sys, grad: g_sys, update: s_stb[3]};

	for (genvar e = 0; e < 6; e++)
	begin : g_el
		fpe_element u_el (
			.i_ref_clk(i_ref_clk),
			.i_rst_n(i_rst_n),
			.i_cfg(cfg[e]),
			.i_meas(meas),
			.i_block(i_block[e] || blocked),
			.o_alarm(el_alarm[e]),
			.o_trip(el_trip[e])
		);
	end

	// Element outputs are already registered; routed out directly
	assign o_alarm = el_alarm;
	assign o_trip = el_trip;

endmodule

// ---- verification/fpe_chk.sv ----
// Port checker for the frequency protection element top level.
// Assumes a bind to fpe_top; it sees only that module's ports.
`timescale 1ns/1ps

module fpe_chk
#(
	parameter int unsigned BLOCK_HOLD_CYC = 500,
	parameter int unsigned FZERO_CYC = 300,
	parameter int unsigned GZERO_CYC = 1000
)
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [2:0] i_zero_cross,
	input wire logic [5:0] i_block,
	input wire logic [5:0] o_alarm,
	input wire logic [5:0] o_trip
);
	// ****************************************
	// Crossing age and assertions
	// ****************************************
	logic [7:0] zc_age;

	// Alarms may only rise a bounded time after a crossing
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			zc_age <= 8'hFF;
		else if (|i_zero_cross)
			zc_age <= 8'h00;
		else if (zc_age != 8'hFF)
			zc_age <= zc_age + 8'h01;
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	setup_ans_a: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready after setup");
	ready_once_a: assert property (o_pready |=> !o_pready)
		else $error("ready held two cycles");
	ready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable))
		else $error("ready without setup");
	err_ready_a: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
		else $error("read data outside access");
	block_clear_a: assert property ((|i_block) |=>
		((o_alarm | o_trip) & $past(i_block)) == 6'h00)
		else $error("block did not clear element");
	trip_alarm_a: assert property ((o_trip & ~o_alarm) == 6'h00)
		else $error("trip without alarm");
	trip_order_a: assert property (
		(o_trip & ~$past(o_trip) & ~$past(o_alarm)) == 6'h00)
		else $error("trip before alarm");
	alarm_upd_a: assert property (
		(o_alarm & ~$past(o_alarm)) != 6'h00 |-> zc_age < 8'hC0)
		else $error("alarm rose without new value");
endmodule

// ---- verification/fpe_front.sv ----
// Voltage front-end model: one crossing pulse per phase per period.
// Assumes the bench changes periods only between crossings.
`timescale 1ns/1ps

module fpe_front
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_per [3],
	output logic [2:0] o_zero_cross
);
	logic [15:0] cnt [3];

	// Staggered phase counters, so crossings drift past each other
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		for (int p = 0; p < 3; p++)
		begin
			if (!i_rst_n)
			begin
				cnt[p] <= 16'(p * 1500);
				o_zero_cross[p] <= 1'b0;
			end
			else
			begin
				cnt[p] <= (cnt[p] >= i_per[p] - 16'h0001) ? 16'h0000 :
					cnt[p] + 16'h0001;
				o_zero_cross[p] <= (cnt[p] == i_per[p] - 16'h0001);
			end
		end
	end
endmodule

// ---- verification/fpe_tb.sv ----
// Self-checking bench of the frequency protection element.
// Assumes package, map header, front-end model and checker compiled.
`timescale 1ns/1ps
`include "fpe_map.svh"

module testbench
	import fpe_pkg::*;
;
	localparam int unsigned HOLD = 500;
	logic ref_clk = 1'b0, rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, err, seen3 = 1'b0, seen4 = 1'b0;
	logic jump = 1'b0;
	logic [2:0] zc, phase_ok = 3'b000;
	logic [15:0] volt_mag = 16'hFFFF;
	logic [5:0] blk = 6'h20, alarm, trip;
	logic [15:0] per [3] = '{16'h1770, 16'h186A, 16'h186A};
	logic [31:0] mode_v [6], thr [6], dly [6];
	int error_cnt = 0, tests_run = 0, cyc = 0;
	integer seed = 32'hf2e13a02;

	always #5 ref_clk = ~ref_clk;

	fpe_top #(.BLOCK_HOLD_CYC(HOLD), .FZERO_CYC(300), .GZERO_CYC(1000))
		u_fpe_top (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_zero_cross(zc), .i_phase_ok(phase_ok),
		.i_volt_mag(volt_mag), .i_phase_jump(jump), .i_block(blk),
		.o_alarm(alarm), .o_trip(trip));
	fpe_front u_fpe_front (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
		.i_per(per), .o_zero_cross(zc));

	// ****************************************
	// Tasks and expectations
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; held until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [11:0] ea(input int e, input int f);
		return 12'(`FPE_ELEM_BASE + 16 * e + 4 * f);
	endfunction

	// Mean of valid phase frequencies in mHz, from the set periods
	function automatic logic [31:0] mean_f(input logic [2:0] ok);
		longint s = 0;
		longint n = 0;
		for (int p = 0; p < 3; p++)
			if (ok[p])
			begin
				s += `FPE_FREQ_NUM / per[p];
				n++;
			end
		return 32'(s / n);
	endfunction

	// Integer division in the design may round either way
	function automatic logic near(input logic [31:0] v, input logic [31:0] e);
		return v <= e + 2 && v + 2 >= e;
	endfunction

	task automatic poll(input logic [31:0] exp);
		int k;
		k = 0;
		do
		begin
			repeat (40) @(posedge ref_clk);
			apb(1'b0, `FPE_FREQ_OFF, 32'h0000_0000);
			k++;
		end
		while (!near(rd, exp) && k < 600);
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Sticky gradient alarms; timeout covers the slowest poll chain
	always @(posedge ref_clk)
	begin
		seen3 <= seen3 | alarm[3];
		seen4 <= seen4 | alarm[4];
		cyc++;
		if (cyc == 32'h0001_86A0)
		begin
			error_cnt++;
			end_sim();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		logic [31:0] v;
		int k;
		int t0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(1'b0, `FPE_WINDOW_OFF, 32'h0000_0000);
		chk(rd, 32'h0203_0200);
		v = $random(seed);
		apb(1'b1, `FPE_VBLOCK_OFF, v);
		apb(1'b0, `FPE_VBLOCK_OFF, 32'h0000_0000);
		chk(rd, {16'h0000, v[15:0]});
		apb(1'b1, `FPE_FREQ_OFF, v);
		chk(err, 1'b0);
		apb(1'b0, 12'h09C, 32'h0000_0000);
		chk(err, 1'b1);
		apb(1'b1, 12'h002, v);
		chk(err, 1'b1);
		for (int m = 0; m < 8; m++)
		begin
			apb(1'b1, ea(5, `FPE_EL_MODE), 32'(m));
			apb(1'b0, ea(5, `FPE_EL_MODE), 32'h0000_0000);
			chk(rd, 32'(m));
		end
		mode_v = '{0, 1, 0, 32'({FPE_DIR_NEG, 1'b0, FPE_MODE_RATE}),
			32'({FPE_DIR_ABS, 1'b0, FPE_MODE_RATE}), 0};
		thr = '{32'h00FB_C520, 32'h00F5_AAA0,
			32'h0098_9680 + (v & 32'h003F_FFFF), 1, 1, 32'h00FB_C520};
		dly = '{32'h0000_3A98, 0, 0, 0, 0, 0};
		for (int e = 0; e < 6; e++)
		begin
			apb(1'b1, ea(e, `FPE_EL_MODE), mode_v[e]);
			apb(1'b1, ea(e, `FPE_EL_THRESH), thr[e]);
			apb(1'b1, ea(e, `FPE_EL_DELAY), dly[e]);
		end
		apb(1'b1, `FPE_VBLOCK_OFF, 32'h0000_1000);
		phase_ok <= 3'b111;
		poll(mean_f(3'b111));
		chk(near(rd, mean_f(3'b111)), 1'b1);
		// Let the elements take the sample just read
		repeat (8) @(posedge ref_clk);
		chk(alarm & 6'h27, 6'h03);
		for (k = 0; k < 7000 && trip[1] !== 1'b1; k++) @(posedge ref_clk);
		chk(trip[1], 1'b1);
		blk <= 6'h21;
		repeat (2) @(posedge ref_clk);
		chk(alarm[0] | trip[0], 1'b0);
		blk <= 6'h20;
		t0 = cyc;
		for (k = 0; k < 30000 && trip[0] !== 1'b1; k++) @(posedge ref_clk);
		chk(trip[0], 1'b1);
		chk(cyc - t0 >= 15000, 1'b1);
		// Drop one phase, then slow the first to make a falling ramp
		phase_ok <= 3'b011;
		poll(mean_f(3'b011));
		chk(near(rd, mean_f(3'b011)), 1'b1);
		per[0] <= 16'h186A;
		k = 0;
		do
		begin
			apb(1'b0, `FPE_GRAD_OFF, 32'h0000_0000);
			k++;
		end
		while (rd[23] !== 1'b1 && k < 5000);
		chk(rd[23], 1'b1);
		poll(mean_f(3'b011));
		repeat (8) @(posedge ref_clk);
		chk(alarm[1], 1'b0);
		chk(seen3, 1'b1);
		chk(seen4, 1'b1);
		// Phase jump: frequency frozen, gradient forced to zero
		jump <= 1'b1;
		@(posedge ref_clk);
		jump <= 1'b0;
		apb(1'b0, `FPE_FLAGS_OFF, 32'h0000_0000);
		chk(rd[19], 1'b1);
		apb(1'b0, `FPE_GRAD_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		// Undervoltage block and its hold after recovery
		volt_mag <= 16'h0800;
		repeat (4) @(posedge ref_clk);
		chk(alarm, 6'h00);
		apb(1'b0, `FPE_FLAGS_OFF, 32'h0000_0000);
		chk(rd[16], 1'b1);
		volt_mag <= 16'hFFFF;
		t0 = cyc;
		apb(1'b0, `FPE_FREQ_OFF, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		k = 0;
		do
		begin
			repeat (20) @(posedge ref_clk);
			apb(1'b0, `FPE_FLAGS_OFF, 32'h0000_0000);
			k++;
		end
		while (rd[16] !== 1'b0 && k < 200);
		chk(rd[16], 1'b0);
		chk(cyc - t0 >= HOLD, 1'b1);
		end_sim();
	end
endmodule

bind fpe_top fpe_chk #(.BLOCK_HOLD_CYC(BLOCK_HOLD_CYC),
	.FZERO_CYC(FZERO_CYC), .GZERO_CYC(GZERO_CYC)) u_fpe_chk (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
	.i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .i_zero_cross(i_zero_cross),
	.i_block(i_block), .o_alarm(o_alarm), .o_trip(o_trip));
